//--- logic/cfwx_pkg.sv
// constants shared by the clear-file and watchdog-clear execute block
package cfwx_pkg;

  // ****************************************************************
  // apb register byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] BANK_OFFSET = 8'h04;
  localparam logic [7:0] INDEX_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] LAST_ADDR_OFFSET = 8'h10;
  localparam logic [7:0] COUNT_OFFSET = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTRL_EXT_BIT = 0;
  localparam int unsigned STATUS_ZERO_BIT = 2;
  localparam int unsigned STATUS_PD_BIT = 3;
  localparam int unsigned STATUS_TO_BIT = 4;
  localparam int unsigned COUNT_WDT_LSB = 16;

  // ****************************************************************
  // widths and address map of the data memory
  // ****************************************************************
  localparam int unsigned FILE_W = 8;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned COUNT_W = 16;
  localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0] CLEAR_VALUE = 8'h00;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RESET_EXT = 1'b0;
  localparam logic [3:0] RESET_BANK = 4'h0;
  localparam logic [11:0] RESET_INDEX = 12'h000;
  localparam logic RESET_ZERO = 1'b0;
  localparam logic RESET_TO = 1'b1;
  localparam logic RESET_PD = 1'b1;
  localparam logic [31:0] RESET_RDATA = 32'h0000_0000;

  typedef enum logic {
    CFWX_APB_WAIT,
    CFWX_APB_DONE
  } cfwx_apb_state_type;

endpackage : cfwx_pkg

//--- logic/cfwx_exec.sv
// execute logic for the clear-file and watchdog-clear instructions
// ******************************************************************
// How it works
// - a clear-file op writes zero into the addressed file register.
// - a clear-file op sets the zero flag and leaves other flags alone.
// - with access bit one, the bank select register gives the bank.
// - with access bit zero and extended clear, the access bank is used, bank ignored.
// - access bit zero plus extended set uses indexed literal offset low.
// - a watchdog-clear op sets timeout and power-down flags only.
// ******************************************************************
`timescale 1ns/1ps

module cfwx_exec (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clear_file_op,
  input wire logic [7:0] file_operand,
  input wire logic access_sel,
  input wire logic watchdog_clear_op,
  input wire logic timeout_event,
  input wire logic sleep_event,
  output logic mem_write,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic watchdog_counter_clear,
  output logic postscaler_clear,
  output logic zero_flag,
  output logic timeout_flag,
  output logic powerdown_flag
);

  // ****************************************************************
  // apb slave state
  // ****************************************************************
  cfwx_pkg::cfwx_apb_state_type apb_state_reg;
  cfwx_pkg::cfwx_apb_state_type apb_state_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic ext_enable_reg;
  logic ext_enable_next;
  logic [3:0] bank_select_register_reg;
  logic [3:0] bank_select_register_next;
  logic [11:0] index_base_reg;
  logic [11:0] index_base_next;
  logic apb_commit;
  logic apb_write;
  logic addr_hit;

  // ****************************************************************
  // execute state
  // ****************************************************************
  logic mem_write_reg;
  logic mem_write_next;
  logic [11:0] mem_addr_reg;
  logic [11:0] mem_addr_next;
  logic [7:0] mem_wdata_reg;
  logic [7:0] mem_wdata_next;
  logic wdt_clear_reg;
  logic wdt_clear_next;
  logic post_clear_reg;
  logic post_clear_next;
  logic zero_flag_reg;
  logic zero_flag_next;
  logic timeout_flag_reg;
  logic timeout_flag_next;
  logic powerdown_flag_reg;
  logic powerdown_flag_next;
  logic [11:0] last_addr_reg;
  logic [11:0] last_addr_next;
  logic [15:0] clear_count_reg;
  logic [15:0] clear_count_next;
  logic [15:0] wdt_count_reg;
  logic [15:0] wdt_count_next;
  logic [11:0] target_addr;

  // decode of the mapped offsets, used for both the write strobe and errors
  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == cfwx_pkg::CTRL_OFFSET) ||
             (addr == cfwx_pkg::BANK_OFFSET) ||
             (addr == cfwx_pkg::INDEX_OFFSET) ||
             (addr == cfwx_pkg::STATUS_OFFSET) ||
             (addr == cfwx_pkg::LAST_ADDR_OFFSET) ||
             (addr == cfwx_pkg::COUNT_OFFSET);
  endfunction : mapped

  // saturating-free wrap counter step, shared by both op counters
  function automatic logic [15:0] bump(input logic [15:0] value, input logic hit);
    bump = hit ? value + 16'h0001 : value;
  endfunction : bump

  // ****************************************************************
  // apb register file
  // ****************************************************************
  // one wait state: pready is registered so every output is a flop
  assign apb_commit = psel && penable && pready_reg;
  assign apb_write = apb_commit && pwrite && mapped(paddr);
  assign addr_hit = mapped(paddr);

  always_comb begin
    apb_state_next = apb_state_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    ext_enable_next = ext_enable_reg;
    bank_select_register_next = bank_select_register_reg;
    index_base_next = index_base_reg;
    case (apb_state_reg)
      cfwx_pkg::CFWX_APB_WAIT: begin
        if (psel && penable) begin
          pready_next = 1'b1;
          pslverr_next = !addr_hit;
          prdata_next = cfwx_pkg::RESET_RDATA;
          apb_state_next = cfwx_pkg::CFWX_APB_DONE;
          if (!pwrite) begin
            case (paddr)
              cfwx_pkg::CTRL_OFFSET: begin
                prdata_next[cfwx_pkg::CTRL_EXT_BIT] = ext_enable_reg;
              end
              cfwx_pkg::BANK_OFFSET: begin
                prdata_next[3:0] = bank_select_register_reg;
              end
              cfwx_pkg::INDEX_OFFSET: begin
                prdata_next[11:0] = index_base_reg;
              end
              cfwx_pkg::STATUS_OFFSET: begin
                prdata_next[cfwx_pkg::STATUS_ZERO_BIT] = zero_flag_reg;
                prdata_next[cfwx_pkg::STATUS_PD_BIT] = powerdown_flag_reg;
                prdata_next[cfwx_pkg::STATUS_TO_BIT] = timeout_flag_reg;
              end
              cfwx_pkg::LAST_ADDR_OFFSET: begin
                prdata_next[11:0] = last_addr_reg;
              end
              cfwx_pkg::COUNT_OFFSET: begin
                prdata_next[15:0] = clear_count_reg;
                prdata_next[31:16] = wdt_count_reg;
              end
              default: begin
                prdata_next = cfwx_pkg::RESET_RDATA;
              end
            endcase
          end
        end
      end
      cfwx_pkg::CFWX_APB_DONE: begin
        apb_state_next = cfwx_pkg::CFWX_APB_WAIT;
        if (apb_write && paddr == cfwx_pkg::CTRL_OFFSET) begin
          ext_enable_next = pwdata[cfwx_pkg::CTRL_EXT_BIT];
        end
        if (apb_write && paddr == cfwx_pkg::BANK_OFFSET) begin
          bank_select_register_next = pwdata[3:0];
        end
        if (apb_write && paddr == cfwx_pkg::INDEX_OFFSET) begin
          index_base_next = pwdata[11:0];
        end
      end
      default: begin
        apb_state_next = cfwx_pkg::CFWX_APB_WAIT;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      apb_state_reg <= cfwx_pkg::CFWX_APB_WAIT;
      prdata_reg <= cfwx_pkg::RESET_RDATA;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      ext_enable_reg <= cfwx_pkg::RESET_EXT;
      bank_select_register_reg <= cfwx_pkg::RESET_BANK;
      index_base_reg <= cfwx_pkg::RESET_INDEX;
    end else begin
      apb_state_reg <= apb_state_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      ext_enable_reg <= ext_enable_next;
      bank_select_register_reg <= bank_select_register_next;
      index_base_reg <= index_base_next;
    end
  end

  // ****************************************************************
  // target address of a clear-file op
  // ****************************************************************
  always_comb begin
    if (access_sel) begin
      target_addr = {bank_select_register_reg, file_operand};
    end else if (ext_enable_reg && file_operand <= cfwx_pkg::ACCESS_SPLIT) begin
      // offset is unsigned and wraps inside the 4k data space
      target_addr = index_base_reg + {4'h0, file_operand};
    end else if (file_operand <= cfwx_pkg::ACCESS_SPLIT) begin
      target_addr = {cfwx_pkg::ACCESS_LOW_BANK, file_operand};
    end else begin
      target_addr = {cfwx_pkg::ACCESS_HIGH_BANK, file_operand};
    end
  end

  // ****************************************************************
  // execute and status flags
  // ****************************************************************
  always_comb begin
    mem_write_next = clear_file_op;
    mem_addr_next = clear_file_op ? target_addr : mem_addr_reg;
    mem_wdata_next = cfwx_pkg::CLEAR_VALUE;
    wdt_clear_next = watchdog_clear_op;
    post_clear_next = watchdog_clear_op;
    last_addr_next = clear_file_op ? target_addr : last_addr_reg;
    clear_count_next = bump(clear_count_reg, clear_file_op);
    wdt_count_next = bump(wdt_count_reg, watchdog_clear_op);
    zero_flag_next = zero_flag_reg;
    timeout_flag_next = timeout_flag_reg;
    powerdown_flag_next = powerdown_flag_reg;
    // software may clear zero, but a clear-file op in the same cycle wins
    if (apb_write && paddr == cfwx_pkg::STATUS_OFFSET) begin
      zero_flag_next = pwdata[cfwx_pkg::STATUS_ZERO_BIT];
    end
    if (clear_file_op) begin
      zero_flag_next = 1'b1;
    end
    if (timeout_event) begin
      timeout_flag_next = 1'b0;
    end
    if (sleep_event) begin
      powerdown_flag_next = 1'b0;
    end
    // set beats a same-cycle clear so a restart is never lost
    if (watchdog_clear_op) begin
      timeout_flag_next = 1'b1;
      powerdown_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mem_write_reg <= 1'b0;
      mem_addr_reg <= 12'h000;
      mem_wdata_reg <= cfwx_pkg::CLEAR_VALUE;
      wdt_clear_reg <= 1'b0;
      post_clear_reg <= 1'b0;
      zero_flag_reg <= cfwx_pkg::RESET_ZERO;
      timeout_flag_reg <= cfwx_pkg::RESET_TO;
      powerdown_flag_reg <= cfwx_pkg::RESET_PD;
      last_addr_reg <= 12'h000;
      clear_count_reg <= 16'h0000;
      wdt_count_reg <= 16'h0000;
    end else begin
      mem_write_reg <= mem_write_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      wdt_clear_reg <= wdt_clear_next;
      post_clear_reg <= post_clear_next;
      zero_flag_reg <= zero_flag_next;
      timeout_flag_reg <= timeout_flag_next;
      powerdown_flag_reg <= powerdown_flag_next;
      last_addr_reg <= last_addr_next;
      clear_count_reg <= clear_count_next;
      wdt_count_reg <= wdt_count_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_write = mem_write_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign watchdog_counter_clear = wdt_clear_reg;
  assign postscaler_clear = post_clear_reg;
  assign zero_flag = zero_flag_reg;
  assign timeout_flag = timeout_flag_reg;
  assign powerdown_flag = powerdown_flag_reg;

endmodule : cfwx_exec

//--- tb/cfwx_exec_checker.sv
// port assertions for the clear-file and watchdog-clear execute block
`timescale 1ns/1ps
module cfwx_exec_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic clear_file_op,
  input wire logic [7:0] file_operand,
  input wire logic access_sel,
  input wire logic watchdog_clear_op,
  input wire logic timeout_event,
  input wire logic sleep_event,
  input wire logic mem_write,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic watchdog_counter_clear,
  input wire logic postscaler_clear,
  input wire logic zero_flag,
  input wire logic timeout_flag,
  input wire logic powerdown_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ****
  // assertions
  // ****
  clear_write_a: assert property (clear_file_op |=> mem_write && mem_wdata == 8'h00)
    else $error("clear-file gave no zero write");
  no_stray_a: assert property (!clear_file_op |=> !mem_write)
    else $error("write strobe without clear-file");
  zero_set_a: assert property (clear_file_op |=> zero_flag)
    else $error("zero flag not set");
  flags_kept_a: assert property (clear_file_op && !watchdog_clear_op && !timeout_event
    && !sleep_event |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("clear-file touched other flags");
  high_bank_a: assert property (clear_file_op && !access_sel && file_operand > 8'h5F
    |=> mem_addr == {4'hF, $past(file_operand)})
    else $error("access bank high half wrong");
  wdt_flags_a: assert property (watchdog_clear_op |=> timeout_flag && powerdown_flag)
    else $error("timeout or power-down flag not set");
  zero_kept_a: assert property (watchdog_clear_op && !clear_file_op && !psel
    |=> $stable(zero_flag))
    else $error("watchdog clear touched zero flag");
  wdt_pulse_a: assert property (watchdog_clear_op |=> watchdog_counter_clear)
    else $error("counter clear missing");
  pulse_cause_a: assert property (watchdog_counter_clear |-> $past(watchdog_clear_op))
    else $error("counter clear without request");
  pair_pulse_a: assert property (postscaler_clear == watchdog_counter_clear)
    else $error("postscaler clear out of step");
  cover property (clear_file_op && access_sel);
  cover property (clear_file_op && !access_sel);
  cover property (clear_file_op && watchdog_clear_op);
endmodule : cfwx_exec_checker

bind cfwx_exec cfwx_exec_checker chk_u (
  .clock(clock), .reset(reset), .psel(psel), .clear_file_op(clear_file_op),
  .file_operand(file_operand), .access_sel(access_sel),
  .watchdog_clear_op(watchdog_clear_op), .timeout_event(timeout_event),
  .sleep_event(sleep_event), .mem_write(mem_write), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .watchdog_counter_clear(watchdog_counter_clear),
  .postscaler_clear(postscaler_clear), .zero_flag(zero_flag),
  .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag)
);

//--- tb/cfwx_far_model.sv
// data memory and watchdog counter on the far side of the block
`timescale 1ns/1ps
module cfwx_far_model (
  input wire logic clock,
  input wire logic mem_write,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [11:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic watchdog_counter_clear,
  input wire logic postscaler_clear,
  output logic [15:0] wdt_count
);
  logic [7:0] mem [4096];
  logic [3:0] post;
  // nonzero fill so that a missed clear shows up
  initial begin
    foreach (mem[i]) mem[i] = 8'hA5;
    wdt_count = 16'h0100;
    post = 4'h5;
  end
  assign rd_data = mem[rd_addr];
  always @(posedge clock) begin
    if (mem_write) mem[mem_addr] <= mem_wdata;
    post <= postscaler_clear ? 4'h0 : post + 4'h1;
    if (watchdog_counter_clear) wdt_count <= 16'h0000;
    else if (post == 4'hF) wdt_count <= wdt_count + 16'h0001;
  end
endmodule : cfwx_far_model

//--- tb/cfwx_exec_tb.sv
// self-checking bench for the clear-file and watchdog-clear block
`timescale 1ns/1ps
module cfwx_exec_tb;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, ev;
  logic clear_file_op, access_sel, watchdog_clear_op, timeout_event, sleep_event;
  logic mem_write, watchdog_counter_clear, postscaler_clear;
  logic zero_flag, timeout_flag, powerdown_flag;
  logic [7:0] paddr, file_operand, mem_wdata, rd_data;
  logic [11:0] mem_addr, rd_addr;
  logic [15:0] wdt_count;
  logic [31:0] pwdata, prdata, rv;
  int errors, checked;
  // ext, access bit, operand, expected target
  logic [21:0] case_t [6] = '{{2'h1, 8'h12, 12'h312}, {2'h0, 8'h20, 12'h020},
    {2'h0, 8'hA0, 12'hFA0}, {2'h2, 8'h5F, 12'h15F}, {2'h2, 8'h80, 12'hF80},
    {2'h3, 8'h34, 12'h334}};
  cfwx_exec dut_u (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear_file_op(clear_file_op), .file_operand(file_operand), .access_sel(access_sel),
    .watchdog_clear_op(watchdog_clear_op), .timeout_event(timeout_event),
    .sleep_event(sleep_event), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .watchdog_counter_clear(watchdog_counter_clear),
    .postscaler_clear(postscaler_clear), .zero_flag(zero_flag),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
  cfwx_far_model far_u (
    .clock(clock), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .rd_addr(rd_addr), .rd_data(rd_data), .watchdog_counter_clear(watchdog_counter_clear),
    .postscaler_clear(postscaler_clear), .wdt_count(wdt_count));
  // ****
  // tasks
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // the master never counts on the wait state; it waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    // no cycle limit here: a hang is ended by the watchdog process
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task op(input logic c, input logic w, input logic [7:0] f, input logic a);
    @(posedge clock);
    clear_file_op <= c;
    watchdog_clear_op <= w;
    file_operand <= f;
    access_sel <= a;
    @(posedge clock);
    clear_file_op <= 1'h0;
    watchdog_clear_op <= 1'h0;
    #1;
  endtask : op
  task end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // ****
  // tests
  // ****
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  initial begin
    #40000;
    errors++;
    end_sim;
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, rd_addr} = {4'h8, 52'h0};
    {clear_file_op, file_operand, access_sel, watchdog_clear_op} = 11'h000;
    {timeout_event, sleep_event, errors, checked} = 0;
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    apb(1'h0, cfwx_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk(rv, (32'h1 << cfwx_pkg::STATUS_TO_BIT) | (32'h1 << cfwx_pkg::STATUS_PD_BIT));
    apb(1'h0, 8'h40, 32'h0000_0000);
    chk({31'h0000_0000, ev}, 32'h0000_0001);
    chk(rv, 32'h0000_0000);
    apb(1'h1, cfwx_pkg::BANK_OFFSET, 32'h0000_0003);
    apb(1'h1, cfwx_pkg::INDEX_OFFSET, 32'h0000_0100);
    @(posedge clock);
    {timeout_event, sleep_event} <= 2'h3;
    @(posedge clock);
    {timeout_event, sleep_event} <= 2'h0;
    @(posedge clock);
    #1;
    chk({timeout_flag, powerdown_flag}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, cfwx_pkg::CTRL_OFFSET, {31'h0000_0000, case_t[i][21]});
      apb(1'h1, cfwx_pkg::STATUS_OFFSET, 32'h0000_0000);
      rd_addr <= case_t[i][11:0];
      #1;
      chk(rd_data, 32'h0000_00A5);
      op(1'h1, 1'h0, case_t[i][19:12], case_t[i][20]);
      chk(mem_addr, case_t[i][11:0]);
      chk({mem_write, mem_wdata}, 32'h0000_0100);
      chk({zero_flag, timeout_flag, powerdown_flag}, 32'h4);
      @(posedge clock);
      #1;
      chk(rd_data, 32'h0000_0000);
    end
    $display("test clear_file done");
    op(1'h1, 1'h1, 8'h40, 1'h0);
    chk({mem_addr, zero_flag, timeout_flag, powerdown_flag}, 32'h0A07);
    apb(1'h1, cfwx_pkg::STATUS_OFFSET, 32'h0000_0000);
    op(1'h0, 1'h1, 8'h00, 1'h0);
    chk({zero_flag, timeout_flag, powerdown_flag}, 32'h3);
    chk({watchdog_counter_clear, postscaler_clear}, 32'h0000_0003);
    @(posedge clock);
    #1;
    chk(wdt_count, 32'h0000_0000);
    repeat (14) @(posedge clock);
    #1;
    chk(wdt_count, 32'h0000_0000);
    apb(1'h0, cfwx_pkg::COUNT_OFFSET, 32'h0000_0000);
    chk(rv, 32'h0002_0007);
    $display("test watchdog done");
    end_sim;
  end
endmodule : cfwx_exec_tb
